// *** logic/rot_ret_pkg.sv ***
package rot_ret_pkg;
    // Instruction fields of a 14-bit word
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int OP_HI = 13;
    localparam int OP_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int FADDR_HI = 6;
    localparam int FADDR_LO = 0;
    localparam int FADDR_W = 7;
    // Opcode fields, bits 13..8
    localparam logic [5:0] OP_ROT_LEFT = 6'h0D;
    localparam logic [5:0] OP_ROT_RIGHT = 6'h0C;
    // Return with literal: 11 01xx kkkk kkkk, bits 13..10
    localparam logic [3:0] OP_RET_LIT = 4'hD;
    // Plain return word
    localparam logic [13:0] OP_RETURN = 14'h0008;
    // Reset values
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic C_RESET = 1'b0;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [12:0] PC_RESET = 13'h0000;
    // Phase counter values, Q1 first
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    typedef enum logic [1:0] {
        OPC_NONE,
        OPC_ROT_LEFT,
        OPC_ROT_RIGHT,
        OPC_RETURN
    } opclass_type;
endpackage

// *** logic/rotate_return_exec.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Rotate-left opcode shifts file value toward MSB through carry only.
// - Rotate-right opcode shifts file value toward LSB through carry only.
// - Destination bit 0 writes working register; 1 writes file back.
// - Rotate completes in one cycle: decode, read, compute, write at Q4.
// - Return-with-literal loads literal to W, pops stack at Q4; then nop.
// - Any return loads program counter from stack top value.
module rotate_return_exec
    import rot_ret_pkg::*;
(
    input wire logic clk_sys,                   // System clock
    input wire logic resetn,                    // Sync reset, active low
    input wire logic [INSTR_W-1:0] instr,       // Fetched instruction word
    input wire logic instr_valid,               // Word valid for this cycle
    input wire logic [DATA_W-1:0] file_rdata,   // File register read data
    input wire logic [PC_W-1:0] stack_top_value,// Top of return stack
    output logic [1:0] phase,                   // Q phase, 0 is Q1
    output logic [FADDR_W-1:0] file_addr,       // File register address
    output logic file_rd,                       // Read strobe in Q2
    output logic file_we,                       // Write strobe in Q4
    output logic [DATA_W-1:0] file_wdata,       // File write data
    output logic [DATA_W-1:0] w_value,          // Working register
    output logic carry_flag,                    // Carry flag
    output logic stack_pop,                     // Pop strobe in Q4
    output logic pc_load,                       // PC load strobe in Q4
    output logic [PC_W-1:0] pc_value,           // Program counter value
    output logic nop_cycle                      // Forced no-operation cycle
);
    // ----------------------------------------
    // Phase sequencer
    // ----------------------------------------
    logic [1:0] phase_reg;
    opclass_type op_reg;
    logic dest_reg;
    logic [FADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] lit_reg;
    logic lit_ret_reg;
    logic [DATA_W-1:0] operand_reg;
    logic [DATA_W-1:0] result_reg;
    logic carry_res_reg;
    logic [DATA_W-1:0] w_reg;
    logic carry_reg;
    logic flush_reg;
    logic flush_pending_reg;
    logic [PC_W-1:0] pc_reg;
    logic [DATA_W-1:0] rot_result;
    logic rot_carry;

    function automatic logic is_lit_return(input logic [INSTR_W-1:0] w);
        return w[OP_HI:OP_HI-3] == OP_RET_LIT;
    endfunction

    function automatic opclass_type classify(input logic [INSTR_W-1:0] w);
        if (w[OP_HI:OP_LO] == OP_ROT_LEFT)
            return OPC_ROT_LEFT;
        else if (w[OP_HI:OP_LO] == OP_ROT_RIGHT)
            return OPC_ROT_RIGHT;
        else if (is_lit_return(w) || w == OP_RETURN)
            return OPC_RETURN;
        else
            return OPC_NONE;
    endfunction

    // Free-running: every instruction cycle is exactly four clocks
    always_ff @(posedge clk_sys) begin
        if (!resetn)
            phase_reg <= PHASE_RESET;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    // Phase views shared by every stage below
    logic in_q1;
    logic in_q2;
    logic in_q3;
    logic in_q4;
    assign in_q1 = (phase_reg == PH_Q1);
    assign in_q2 = (phase_reg == PH_Q2);
    assign in_q3 = (phase_reg == PH_Q3);
    assign in_q4 = (phase_reg == PH_Q4);

    // ----------------------------------------
    // Q1 decode
    // ----------------------------------------
    // The word after a return is already fetched; it is discarded, giving
    // the second, empty cycle of a branch.
    logic take_word;
    assign take_word = in_q1 && instr_valid && !flush_pending_reg;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            op_reg <= OPC_NONE;
            lit_ret_reg <= 1'b0;
        end else if (in_q1) begin
            if (take_word) begin
                op_reg <= classify(instr);
                lit_ret_reg <= is_lit_return(instr);
            end else begin
                op_reg <= OPC_NONE;
                lit_ret_reg <= 1'b0;
            end
        end
    end

    // Fields are only used while op_reg says so, so they may go stale
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dest_reg <= 1'b0;
            addr_reg <= '0;
        end else if (take_word) begin
            dest_reg <= instr[DEST_BIT];
            addr_reg <= instr[FADDR_HI:FADDR_LO];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn)
            lit_reg <= '0;
        else if (take_word)
            lit_reg <= instr[DATA_W-1:0];
    end

    // ----------------------------------------
    // Q2 read, Q3 process
    // ----------------------------------------
    logic is_rot;
    logic is_ret;
    assign is_rot = (op_reg == OPC_ROT_LEFT) || (op_reg == OPC_ROT_RIGHT);
    assign is_ret = (op_reg == OPC_RETURN);

    always_ff @(posedge clk_sys) begin
        if (!resetn)
            operand_reg <= '0;
        else if (in_q2)
            operand_reg <= file_rdata;
    end

    // Registering the rotate at Q3 keeps the Q4 write flop to flop
    rotate_unit #(
        .WIDTH(DATA_W)
    ) rotate_unit_inst (
        .operand(operand_reg),
        .carry_in(carry_reg),
        .left(op_reg == OPC_ROT_LEFT),
        .result(rot_result),
        .carry_out(rot_carry)
    );

    always_ff @(posedge clk_sys) begin
        if (!resetn)
            result_reg <= '0;
        else if (in_q3)
            result_reg <= rot_result;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn)
            carry_res_reg <= C_RESET;
        else if (in_q3)
            carry_res_reg <= rot_carry;
    end

    // ----------------------------------------
    // Q4 write back
    // ----------------------------------------
    // Carry is the only status bit a rotate touches; a return leaves it
    always_ff @(posedge clk_sys) begin
        if (!resetn)
            carry_reg <= C_RESET;
        else if (in_q4 && is_rot)
            carry_reg <= carry_res_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            w_reg <= W_RESET;
        end else if (in_q4) begin
            if (is_rot && !dest_reg)
                w_reg <= result_reg;
            else if (is_ret && lit_ret_reg)
                w_reg <= lit_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn)
            pc_reg <= PC_RESET;
        else if (in_q4 && is_ret)
            pc_reg <= stack_top_value;
    end

    // Both flags rise at the Q4 edge of a return, so the marker covers all
    // four phases of the discarded cycle; pending only guards the next
    // decode and clears once that decode has been refused.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            flush_pending_reg <= 1'b0;
            flush_reg <= 1'b0;
        end else if (in_q4) begin
            flush_pending_reg <= is_ret;
            flush_reg <= is_ret;
        end else if (in_q1) begin
            flush_pending_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Strobes come straight from the phase, so they stand one clock only
    assign phase = phase_reg;
    assign file_addr = addr_reg;
    assign file_rd = in_q2 && is_rot;
    assign file_we = in_q4 && is_rot && dest_reg;
    assign file_wdata = result_reg;
    assign w_value = w_reg;
    assign carry_flag = carry_reg;
    assign stack_pop = in_q4 && is_ret;
    assign pc_load = in_q4 && is_ret;
    assign pc_value = pc_reg;
    assign nop_cycle = flush_reg;
endmodule

// *** logic/rotate_unit.sv ***
`timescale 1ns/1ps
module rotate_unit
    import rot_ret_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input wire logic [WIDTH-1:0] operand, // Value read from file register
    input wire logic carry_in,            // Carry flag before instruction
    input wire logic left,                // 1 rotates left, 0 right
    output logic [WIDTH-1:0] result,      // Rotated value
    output logic carry_out                // New carry flag
);
    always_comb begin
        if (left) begin
            result = {operand[WIDTH-2:0], carry_in};
            carry_out = operand[WIDTH-1];
        end else begin
            result = {carry_in, operand[WIDTH-1:1]};
            carry_out = operand[0];
        end
    end
endmodule

// *** verif/file_stack_model.sv ***
`timescale 1ns/1ps
module file_stack_model
    import rot_ret_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic [FADDR_W-1:0] file_addr, // Address
    input wire logic file_rd, // Read strobe
    input wire logic file_we, // Write strobe
    input wire logic [DATA_W-1:0] file_wdata, // Write data
    input wire logic stack_pop, // Pop strobe
    output logic [DATA_W-1:0] file_rdata, // Read data
    output logic [PC_W-1:0] stack_top_value // Stack top
);
    logic [DATA_W-1:0] mem_reg [0:127];
    logic [PC_W-1:0] stk_reg [0:7];
    logic [2:0] sp_reg = 3'h0;
    // Inverted data off-strobe, so a read at the wrong phase cannot match
    assign file_rdata = file_rd ? mem_reg[file_addr] : ~mem_reg[file_addr];
    assign stack_top_value = stk_reg[sp_reg];
    always @(posedge clk_sys) begin
        if (file_we)
            mem_reg[file_addr] <= file_wdata;
        if (stack_pop)
            sp_reg <= sp_reg - 3'h1;
    end
endmodule

// *** verif/rot_ret_monitor.sv ***
`timescale 1ns/1ps
module rot_ret_monitor
    import rot_ret_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic resetn, // Reset
    input wire logic [INSTR_W-1:0] instr, // Word
    input wire logic instr_valid, // Valid
    input wire logic [DATA_W-1:0] file_rdata, // Read data
    input wire logic [PC_W-1:0] stack_top_value, // Stack top
    input wire logic [1:0] phase, // Phase
    input wire logic file_rd, // Read
    input wire logic file_we, // Write
    input wire logic [DATA_W-1:0] file_wdata, // Write data
    input wire logic [DATA_W-1:0] w_value, // W
    input wire logic carry_flag, // Carry
    input wire logic stack_pop, // Pop
    input wire logic pc_load, // PC load
    input wire logic [PC_W-1:0] pc_value, // PC
    input wire logic nop_cycle // Nop slot
);
    logic [INSTR_W-1:0] op_reg;
    logic live_reg;
    logic cin_reg;
    logic [DATA_W-1:0] fv_reg;
    always_ff @(posedge clk_sys) begin
        if (!resetn)
            live_reg <= 1'b0;
        else if (phase == 2'h0)
            live_reg <= instr_valid && !nop_cycle;
    end
    always_ff @(posedge clk_sys) begin
        if (phase == 2'h0) begin
            op_reg <= instr;
            cin_reg <= carry_flag;
        end
        if (phase == 2'h1)
            fv_reg <= file_rdata;
    end
    wire rl = live_reg && op_reg[OP_HI:OP_LO] == OP_ROT_LEFT;
    wire rot = rl || (live_reg && op_reg[OP_HI:OP_LO] == OP_ROT_RIGHT);
    wire d = op_reg[DEST_BIT];
    wire lit = live_reg && op_reg[13:10] == OP_RET_LIT;
    wire ret = lit || (live_reg && op_reg == OP_RETURN);
    wire [7:0] res = rl ? {fv_reg[6:0], cin_reg} : {cin_reg, fv_reg[7:1]};
    wire c_new = rl ? fv_reg[7] : fv_reg[0];
    wire q4 = phase == 2'h3;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_phase_steps: assert property (
        1'b1 |=> phase == $past(phase) + 2'h1)
        else $error("phase sequence broken");
    a_read_in_q2: assert property (
        file_rd == (phase == 2'h1 && rot))
        else $error("file read strobe misplaced");
    a_write_in_q4: assert property (
        file_we == (q4 && rot && d))
        else $error("file write strobe misplaced");
    a_rot_file_data: assert property (
        q4 && rot && d |-> file_wdata == res ##1 $stable(w_value))
        else $error("file write back wrong");
    a_rot_to_w: assert property (
        q4 && rot && !d |=> w_value == $past(res))
        else $error("rotate result in w wrong");
    a_rot_carry_out: assert property (
        q4 && rot |=> carry_flag == $past(c_new))
        else $error("rotate carry wrong");
    a_pop_strobes: assert property (
        {stack_pop, pc_load} == {2{q4 && ret}})
        else $error("pop or pc load misplaced");
    a_ret_pc_load: assert property (
        q4 && ret |=> pc_value == $past(stack_top_value))
        else $error("pc not loaded from stack");
    a_lit_to_w: assert property (
        q4 && lit |=> w_value == $past(op_reg[7:0]))
        else $error("literal not in w");
    a_nop_slot: assert property (
        q4 && ret |=> nop_cycle [*4] ##1 !nop_cycle)
        else $error("no-operation cycle wrong");
endmodule
bind rotate_return_exec rot_ret_monitor mon_inst (.clk_sys, .resetn, .instr,
    .instr_valid, .file_rdata, .stack_top_value, .phase, .file_rd, .file_we,
    .file_wdata, .w_value, .carry_flag, .stack_pop, .pc_load, .pc_value,
    .nop_cycle);

// *** verif/rotate_return_exec_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
    fail_count++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module rotate_return_exec_test;
    import rot_ret_pkg::*;
    logic clk_sys = 1'b0, resetn = 1'b0, instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0] rd, wd, w;
    logic [12:0] stv, pc;
    logic [6:0] fa;
    logic [1:0] phase;
    logic frd, fwe, c, pop, nop;
    int fail_count = 0;
    int total_checks = 0;
    always #2 clk_sys = ~clk_sys;
    rotate_return_exec rotate_return_exec_inst (.clk_sys, .resetn, .instr,
        .instr_valid, .file_rdata(rd), .stack_top_value(stv), .phase,
        .file_addr(fa), .file_rd(frd), .file_we(fwe), .file_wdata(wd),
        .w_value(w), .carry_flag(c), .stack_pop(pop), .pc_load(),
        .pc_value(pc), .nop_cycle(nop));
    file_stack_model file_stack_model_inst (.clk_sys, .file_addr(fa),
        .file_rd(frd), .file_we(fwe), .file_wdata(wd), .stack_pop(pop),
        .file_rdata(rd), .stack_top_value(stv));
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One word per instruction cycle, presented in Q1
    task issue(input logic [13:0] word);
        int n;
        n = 0;
        while (phase !== 2'h0 && n < 8) begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n == 8) begin
            fail_count++;
            final_report();
        end else begin
            instr = word;
            instr_valid = 1'b1;
            @(posedge clk_sys);
            #1 instr_valid = 1'b0;
            repeat (3) @(posedge clk_sys);
            #1;
        end
    endtask
    task t_rot_to_w;
        file_stack_model_inst.mem_reg[16] = 8'hE6;
        issue(14'h0D10);
        `CHK("w", 8'hCC, w)
        `CHK("c", 1'b1, c)
        issue(14'h0C10);
        `CHK("w", 8'hF3, w)
        `CHK("c", 1'b0, c)
        `CHK("f", 8'hE6, file_stack_model_inst.mem_reg[16])
    endtask
    task t_rot_to_file;
        file_stack_model_inst.mem_reg[33] = 8'h81;
        file_stack_model_inst.mem_reg[34] = 8'h01;
        issue(14'h0DA1);
        `CHK("f", 8'h02, file_stack_model_inst.mem_reg[33])
        `CHK("w", 8'hF3, w)
        issue(14'h0CA2);
        `CHK("f", 8'h80, file_stack_model_inst.mem_reg[34])
        `CHK("c", 1'b1, c)
    endtask
    task t_returns;
        file_stack_model_inst.stk_reg[0] = 13'h0123;
        file_stack_model_inst.stk_reg[1] = 13'h1ABC;
        file_stack_model_inst.sp_reg = 3'h1;
        issue(14'h345A);
        `CHK("w", 8'h5A, w)
        `CHK("pc", 13'h1ABC, pc)
        `CHK("nop", 1'b1, nop)
        issue(14'h0D10);
        `CHK("w", 8'h5A, w)
        `CHK("nop", 1'b0, nop)
        issue(14'h0008);
        `CHK("pc", 13'h0123, pc)
        `CHK("c", 1'b1, c)
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 resetn = 1'b1;
        t_rot_to_w();
        t_rot_to_file();
        t_returns();
        final_report();
    end
endmodule
